// ---- rtl/dtc_pkg.sv ----
// package: register map, field positions, reset values and timing counts of the dual timebase capture timer
package dtc_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_TB2_CSR     = 8'h08;
    localparam logic [7:0] IDX_RELOAD      = 8'h09;
    localparam logic [7:0] IDX_RELOAD_CNT  = 8'h0a;
    localparam logic [7:0] IDX_TB1_CSR     = 8'h0b;
    localparam logic [7:0] IDX_CAPTURE     = 8'h0c;
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 32;
    localparam int         BE_W            = 4;
    localparam logic [ADDR_W-1:0] ADDR_TB2_CSR    = ADDR_W'({IDX_TB2_CSR, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_RELOAD     = ADDR_W'({IDX_RELOAD, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_RELOAD_CNT = ADDR_W'({IDX_RELOAD_CNT, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_TB1_CSR    = ADDR_W'({IDX_TB1_CSR, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE    = ADDR_W'({IDX_CAPTURE, 2'b00});

    // field positions in the timebase-2 control/status register
    localparam int TB2_FLAG_BIT   = 0;
    localparam int TB2_IRQ_EN_BIT = 1;
    // field positions in the timebase-1/capture control/status register
    localparam int TB1_FLAG_BIT   = 3;
    localparam int TB1_IRQ_EN_BIT = 4;
    localparam int PERIOD_SEL_BIT = 5;
    localparam int CAP_FLAG_BIT   = 6;
    localparam int CAP_IRQ_EN_BIT = 7;

    // reset values
    localparam logic [7:0] RELOAD_RST   = 8'h00;
    localparam logic [7:0] CAPTURE_RST  = 8'h00;
    localparam logic [7:0] CNT1_RST     = 8'h00;

    // timing: oscillator divided by 32 feeds both counters
    localparam int         PRESC_DIV    = 32;
    localparam int         PRESC_W      = 5;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);
    localparam logic [7:0] CNT1_TOP     = 8'hf9;
    localparam logic [7:0] CNT2_TOP     = 8'hff;
    // base periods in oscillator cycles for the two period selections
    localparam int         TB1_PERIOD_SHORT = 8000;
    localparam int         TB1_PERIOD_LONG  = 16000;
    localparam int         TB1_CNT_SPAN     = TB1_PERIOD_SHORT / PRESC_DIV;
endpackage

// ---- rtl/dtc_timer.sv ----
// design: dual timebase counters with input capture behind an Avalon-MM slave
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module dtc_timer (
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_i,
    input  wire logic [dtc_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                         avs_read_i,
    input  wire logic                         avs_write_i,
    input  wire logic [dtc_pkg::DATA_W-1:0]   avs_writedata_i,
    input  wire logic [dtc_pkg::BE_W-1:0]     avs_byteenable_i,
    output logic      [dtc_pkg::DATA_W-1:0]   avs_readdata_o,
    output logic                              avs_waitrequest_o,
    input  wire logic                         halt_i,
    input  wire logic                         capture_pin_i,
    output logic                              irq_fixed_base_o,
    output logic                              irq_reload_base_o,
    output logic                              irq_capture_o
);
    import dtc_pkg::*;

    logic [PRESC_W-1:0] presc_q;
    logic               tick;
    logic [7:0]         count1_q;
    logic               half_q;
    logic               c1_wrap;
    logic               fixed_evt;
    logic [7:0]         count_bits_q;
    logic [7:0]         reload_bits_q;
    logic               c2_ovf;
    logic               fixed_base_flag_q;
    logic               fixed_base_irq_en_q;
    logic               period_double_sel_q;
    logic               reload_base_flag_q;
    logic               reload_base_irq_en_q;
    logic               capture_flag_q;
    logic               capture_irq_en_q;
    logic [7:0]         captured_bits_q;
    logic               pin_meta_q;
    logic               pin_sync_q;
    logic               pin_prev_q;
    logic               pin_edge;
    logic               cap_take;
    logic               wait_q;
    logic               rd_fire;
    logic               wr_fire;
    logic               wr_lane0;
    logic [7:0]         rd_byte;
    logic [DATA_W-1:0]  readdata_q;
    logic               irq_fixed_q;
    logic               irq_reload_q;
    logic               irq_capture_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, read side effects when the read is first seen
    ////////////////////////////////////////////////////////////////////////////
    assign rd_fire  = avs_read_i && wait_q;
    assign wr_fire  = avs_write_i && !wait_q;
    assign wr_lane0 = wr_fire && avs_byteenable_i[0];

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (avs_address_i)
            ADDR_TB2_CSR: begin
                rd_byte[TB2_IRQ_EN_BIT] = reload_base_irq_en_q;
                rd_byte[TB2_FLAG_BIT]   = reload_base_flag_q;
            end
            ADDR_RELOAD:     rd_byte = reload_bits_q;
            ADDR_RELOAD_CNT: rd_byte = count_bits_q;
            ADDR_TB1_CSR: begin
                rd_byte[CAP_IRQ_EN_BIT] = capture_irq_en_q;
                rd_byte[CAP_FLAG_BIT]   = capture_flag_q;
                rd_byte[PERIOD_SEL_BIT] = period_double_sel_q;
                rd_byte[TB1_IRQ_EN_BIT] = fixed_base_irq_en_q;
                rd_byte[TB1_FLAG_BIT]   = fixed_base_flag_q;
            end
            ADDR_CAPTURE:    rd_byte = captured_bits_q;
            default:         rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_q <= '0;
        end else if (rd_fire) begin
            readdata_q <= {{(DATA_W-8){1'b0}}, rd_byte};
        end
    end

    assign avs_readdata_o    = readdata_q;
    assign avs_waitrequest_o = wait_q;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler: divides the clock by 32, frozen in halt
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            presc_q <= '0;
        end else if (!halt_i) begin
            presc_q <= presc_q + PRESC_W'(1);
        end
    end

    assign tick = !halt_i && (presc_q == PRESC_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // counter 1: hidden timebase, 250 counts per wrap
    ////////////////////////////////////////////////////////////////////////////
    assign c1_wrap   = tick && (count1_q == CNT1_TOP);
    assign fixed_evt = c1_wrap && (!period_double_sel_q || half_q);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count1_q <= CNT1_RST;
        end else if (c1_wrap) begin
            count1_q <= CNT1_RST;
        end else if (tick) begin
            count1_q <= count1_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            half_q <= 1'b0;
        end else if (!period_double_sel_q) begin
            half_q <= 1'b0;
        end else if (c1_wrap) begin
            half_q <= !half_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter 2: auto-reload, reload value taken only at overflow
    ////////////////////////////////////////////////////////////////////////////
    assign c2_ovf = tick && (count_bits_q == CNT2_TOP);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count_bits_q <= RELOAD_RST;
        end else if (c2_ovf) begin
            count_bits_q <= reload_bits_q;
        end else if (tick) begin
            count_bits_q <= count_bits_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reload_bits_q <= RELOAD_RST;
        end else if (wr_lane0 && avs_address_i == ADDR_RELOAD) begin
            reload_bits_q <= avs_writedata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control bits written by software; flag bits ignore writes
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fixed_base_irq_en_q <= 1'b0;
            period_double_sel_q <= 1'b0;
            capture_irq_en_q    <= 1'b0;
        end else if (wr_lane0 && avs_address_i == ADDR_TB1_CSR) begin
            fixed_base_irq_en_q <= avs_writedata_i[TB1_IRQ_EN_BIT];
            period_double_sel_q <= avs_writedata_i[PERIOD_SEL_BIT];
            capture_irq_en_q    <= avs_writedata_i[CAP_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reload_base_irq_en_q <= 1'b0;
        end else if (wr_lane0 && avs_address_i == ADDR_TB2_CSR) begin
            reload_base_irq_en_q <= avs_writedata_i[TB2_IRQ_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event flags: set by hardware, cleared by a register read, set wins
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fixed_base_flag_q <= 1'b0;
        end else if (fixed_evt) begin
            fixed_base_flag_q <= 1'b1;
        end else if (rd_fire && avs_address_i == ADDR_TB1_CSR) begin
            fixed_base_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reload_base_flag_q <= 1'b0;
        end else if (c2_ovf) begin
            reload_base_flag_q <= 1'b1;
        end else if (rd_fire && avs_address_i == ADDR_TB2_CSR) begin
            reload_base_flag_q <= 1'b0;
        end
    end

    // capture flag is defined low at reset; software still reads the capture register first
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            capture_flag_q <= 1'b0;
        end else if (cap_take) begin
            capture_flag_q <= 1'b1;
        end else if (rd_fire && avs_address_i == ADDR_CAPTURE) begin
            capture_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input capture: synchroniser, edge detect, latch of counter 1
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= capture_pin_i;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign pin_edge = pin_sync_q ^ pin_prev_q;
    assign cap_take = pin_edge && !capture_flag_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            captured_bits_q <= CAPTURE_RST;
        end else if (cap_take) begin
            captured_bits_q <= count1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt requests, registered
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_fixed_q   <= 1'b0;
            irq_reload_q  <= 1'b0;
            irq_capture_q <= 1'b0;
        end else begin
            irq_fixed_q   <= fixed_base_flag_q && fixed_base_irq_en_q;
            irq_reload_q  <= reload_base_flag_q && reload_base_irq_en_q;
            irq_capture_q <= capture_flag_q && capture_irq_en_q;
        end
    end

    assign irq_fixed_base_o  = irq_fixed_q;
    assign irq_reload_base_o = irq_reload_q;
    assign irq_capture_o     = irq_capture_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    logic [5:0] gap_q;
    logic       seen_tick_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q       <= '0;
            seen_tick_q <= 1'b0;
        end else if (tick) begin
            gap_q       <= '0;
            seen_tick_q <= 1'b1;
        end else if (!halt_i) begin
            gap_q       <= gap_q + 6'h01;
        end
    end

    AST_TICK_SPACING: assert property (tick && seen_tick_q |-> gap_q == 6'h1f)
        else $error("prescaler tick spacing is not 32 cycles");
    AST_CNT1_WRAP: assert property (tick && count1_q == 8'hf9 |=> count1_q == 8'h00)
        else $error("counter 1 did not wrap from f9 to 00");
    AST_CNT1_RANGE: assert property (count1_q <= 8'hf9)
        else $error("counter 1 left its range");
    AST_TB1_SHORT: assert property (!period_double_sel_q && c1_wrap |=> fixed_base_flag_q)
        else $error("timebase 1 flag not set at wrap");
    AST_TB1_LONG: assert property ($rose(fixed_base_flag_q) && $past(period_double_sel_q) |-> $past(half_q))
        else $error("doubled period raised flag on wrong wrap");
    AST_TB1_CLEAR: assert property (rd_fire && avs_address_i == ADDR_TB1_CSR && !fixed_evt
                                    |=> !fixed_base_flag_q)
        else $error("timebase 1 flag not cleared by read");
    AST_SET_WINS: assert property (c2_ovf && rd_fire && avs_address_i == ADDR_TB2_CSR
                                   |=> reload_base_flag_q)
        else $error("reload flag event lost on clear");
    AST_CNT2_RELOAD: assert property (c2_ovf |=> count_bits_q == $past(reload_bits_q) && reload_base_flag_q)
        else $error("counter 2 did not reload at overflow");
    AST_RELOAD_DEFER: assert property (!tick |=> count_bits_q == $past(count_bits_q))
        else $error("counter 2 changed without a tick");
    AST_CAP_VALUE: assert property (pin_edge && !capture_flag_q |=> captured_bits_q == $past(count1_q)
                                    && capture_flag_q)
        else $error("capture did not latch counter 1");
    AST_CAP_HOLD: assert property (capture_flag_q |=> $stable(captured_bits_q))
        else $error("capture register changed while flag set");
    AST_IRQ_CAP: assert property (capture_flag_q && capture_irq_en_q |=> irq_capture_o)
        else $error("capture interrupt not raised");
    AST_HALT: assert property (halt_i |=> $stable(count1_q) && $stable(count_bits_q))
        else $error("counters moved in halt");
    AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && wait_q |=> !wait_q)
        else $error("waitrequest did not drop after one cycle");
    AST_WAIT_IDLE: assert property (!avs_read_i && !avs_write_i |=> wait_q)
        else $error("waitrequest low without a request");
    AST_RDATA_UPPER: assert property (avs_readdata_o[DATA_W-1:8] == '0)
        else $error("read data upper bits not zero");

    // flag clears, interrupt paths, counter steps
    AST_TB1_HOLD: assert property (fixed_base_flag_q && !(rd_fire && avs_address_i == ADDR_TB1_CSR)
                                   |=> fixed_base_flag_q)
        else $error("timebase 1 flag lost without a read");
    AST_TB1_SET: assert property (fixed_evt |=> fixed_base_flag_q)
        else $error("timebase 1 event did not set the flag");
    AST_IRQ_FIXED: assert property (fixed_base_flag_q && fixed_base_irq_en_q |=> irq_fixed_base_o)
        else $error("timebase 1 interrupt not raised");
    AST_TB2_CLEAR: assert property (rd_fire && avs_address_i == ADDR_TB2_CSR && !c2_ovf
                                    |=> !reload_base_flag_q)
        else $error("timebase 2 flag not cleared by read");
    AST_IRQ_RELOAD: assert property (reload_base_flag_q && reload_base_irq_en_q |=> irq_reload_base_o)
        else $error("timebase 2 interrupt not raised");
    AST_CNT2_STEP: assert property (tick && count_bits_q != CNT2_TOP
                                    |=> count_bits_q == $past(count_bits_q) + 8'h01)
        else $error("counter 2 did not step on a tick");
    AST_RELOAD_WRITE: assert property (wr_lane0 && avs_address_i == ADDR_RELOAD
                                       |=> reload_bits_q == $past(avs_writedata_i[7:0]))
        else $error("reload register did not take the written value");
    AST_CAP_CLEAR: assert property (rd_fire && avs_address_i == ADDR_CAPTURE && !cap_take
                                    |=> !capture_flag_q)
        else $error("capture flag not cleared by capture read");
    AST_CAP_ONLY_READ: assert property (capture_flag_q && !(rd_fire && avs_address_i == ADDR_CAPTURE)
                                        |=> capture_flag_q)
        else $error("capture flag cleared without a capture read");
    AST_IRQ_QUIET: assert property (!(capture_flag_q && capture_irq_en_q) |=> !irq_capture_o)
        else $error("capture interrupt raised without flag and enable");
    AST_CAP_SYNC: assert property (pin_edge |-> $past(capture_pin_i, 2) != $past(capture_pin_i, 3))
        else $error("capture edge not from two synchronised samples");
    AST_HALT_PRESC: assert property (halt_i |=> $stable(presc_q))
        else $error("prescaler moved in halt");

    COV_TB1_EVENT: cover property (fixed_evt && period_double_sel_q);
    COV_RELOAD: cover property (c2_ovf && reload_bits_q != 8'h00);
    COV_CAPTURE: cover property (cap_take ##[1:200] (rd_fire && avs_address_i == ADDR_CAPTURE));
    COV_CAP_BLOCKED: cover property (pin_edge && capture_flag_q);
    COV_SET_WINS: cover property (c2_ovf && rd_fire && avs_address_i == ADDR_TB2_CSR);
endmodule

// ---- testbench/dtc_timer_bench.sv ----
// testbench: self-checking register, timebase, reload, capture and halt tests of the timer
`timescale 1ns/1ps
module dtc_timer_bench;
    import dtc_pkg::*;
    logic        clk_sys_i;
    logic        rst_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        halt_i;
    logic        capture_pin_i;
    logic        irq_fixed_base_o;
    logic        irq_reload_base_o;
    logic        irq_capture_o;
    int          miscompares;
    int          n_tests;
    int          cyc;

    dtc_timer i_dtc_timer (
        .clk_sys_i         (clk_sys_i),
        .rst_i             (rst_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .halt_i            (halt_i),
        .capture_pin_i     (capture_pin_i),
        .irq_fixed_base_o  (irq_fixed_base_o),
        .irq_reload_base_o (irq_reload_base_o),
        .irq_capture_o     (irq_capture_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // edges since reset release, matches the design's tick numbering
    always @(posedge clk_sys_i) begin
        if (rst_i) cyc <= 0;
        else cyc <= cyc + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        chk({31'b0, avs_waitrequest_o}, 32'h0);
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_read_i    <= 1'b1;
        bus_wait();
        d = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys_i);
        avs_address_i    <= a;
        avs_writedata_i  <= d;
        avs_byteenable_i <= be;
        avs_write_i      <= 1'b1;
        bus_wait();
        avs_write_i <= 1'b0;
    endtask

    // sel 0 fixed, 1 reload, 2 capture; returns edge count at the rise
    task automatic wait_irq(input int sel, output int t);
        logic was;
        logic cur;
        int   n;
        was = 1'b1;
        for (n = 0; n < 20000; n++) begin
            @(posedge clk_sys_i);
            cur = (sel == 0) ? irq_fixed_base_o : (sel == 1) ? irq_reload_base_o : irq_capture_o;
            if (cur === 1'b1 && was === 1'b0) break;
            was = cur;
        end
        t = cyc;
        chk(32'(n < 20000), 32'h1);
    endtask

    // launch mid-tick so the sync delay cannot straddle a count; returns the expected capture
    task automatic cap_edge(input logic lvl, output logic [31:0] exp);
        while ((cyc % PRESC_DIV) != 7) @(posedge clk_sys_i);
        exp = 32'(((cyc + 1) / PRESC_DIV) % TB1_CNT_SPAN);
        capture_pin_i <= lvl;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        bus_rd(ADDR_RELOAD_CNT, d);
        chk(d, 32'h0);
        bus_rd(ADDR_CAPTURE, d);
        chk(d, 32'h0);
        bus_rd(ADDR_TB2_CSR, d);
        chk(d, 32'h0);
        bus_rd(ADDR_RELOAD, d);
        chk(d, 32'h0);
        bus_rd(ADDR_TB1_CSR, d);
        chk(d, 32'h0);
        bus_wr(ADDR_TB2_CSR, 32'h01, 4'h1);
        bus_rd(ADDR_TB2_CSR, d);
        chk(d, 32'h0);
        bus_wr(ADDR_TB1_CSR, 32'h48, 4'h1);
        bus_rd(ADDR_TB1_CSR, d);
        chk(d, 32'h0);
        bus_wr(ADDR_RELOAD, 32'h55, 4'h0);
        bus_rd(ADDR_RELOAD, d);
        chk(d, 32'h0);
        bus_wr(ADDR_RELOAD, 32'h5a, 4'h1);
        bus_rd(ADDR_RELOAD, d);
        chk(d, 32'h5a);
        bus_rd(8'h00, d);
        chk(d, 32'h0);
        $display("test reset_values done");
    endtask

    task automatic t_fixed;
        int          t0, t1, t2, t3;
        logic [31:0] d;
        bus_rd(ADDR_TB1_CSR, d);
        bus_wr(ADDR_TB1_CSR, 32'h10, 4'h1);
        wait_irq(0, t0);
        bus_rd(ADDR_TB1_CSR, d);
        chk(d & 32'h18, 32'h18);
        bus_rd(ADDR_TB1_CSR, d);
        chk(d & 32'h08, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        chk({31'b0, irq_fixed_base_o}, 32'h0);
        wait_irq(0, t1);
        chk(32'(t1 - t0), 32'(TB1_PERIOD_SHORT));
        bus_wr(ADDR_TB1_CSR, 32'h30, 4'h1);
        bus_rd(ADDR_TB1_CSR, d);
        wait_irq(0, t2);
        bus_rd(ADDR_TB1_CSR, d);
        wait_irq(0, t3);
        chk(32'(t3 - t2), 32'(TB1_PERIOD_LONG));
        $display("test fixed_timebase done");
    endtask

    task automatic t_reload;
        int          t0, t1, t2;
        logic [31:0] d;
        bus_wr(ADDR_RELOAD, 32'hfc, 4'h1);
        bus_rd(ADDR_TB2_CSR, d);
        bus_wr(ADDR_TB2_CSR, 32'h02, 4'h1);
        wait_irq(1, t0);
        bus_rd(ADDR_TB2_CSR, d);
        chk(d, 32'h03);
        bus_rd(ADDR_RELOAD_CNT, d);
        chk(32'(d >= 32'hfc), 32'h1);
        bus_wr(ADDR_RELOAD, 32'hf0, 4'h1);
        wait_irq(1, t1);
        chk(32'(t1 - t0), 32'd128);
        bus_rd(ADDR_TB2_CSR, d);
        wait_irq(1, t2);
        chk(32'(t2 - t1), 32'd512);
        // first read lands on the next overflow edge: the new event must survive the clear
        while (cyc < t2 + 508) @(posedge clk_sys_i);
        bus_rd(ADDR_TB2_CSR, d);
        bus_rd(ADDR_TB2_CSR, d);
        chk(d, 32'h03);
        bus_rd(ADDR_TB2_CSR, d);
        bus_rd(ADDR_TB2_CSR, d);
        chk(d, 32'h02);
        $display("test reload_counter done");
    endtask

    task automatic t_capture;
        int          t0;
        logic [31:0] d;
        logic [31:0] exp;
        bus_rd(ADDR_CAPTURE, d);
        bus_wr(ADDR_TB1_CSR, 32'h80, 4'h1);
        cap_edge(1'b1, exp);
        repeat (10) @(posedge clk_sys_i);
        bus_rd(ADDR_CAPTURE, d);
        chk(d, exp);
        cap_edge(1'b0, exp);
        wait_irq(2, t0);
        bus_rd(ADDR_TB1_CSR, d);
        chk(d & 32'hc0, 32'hc0);
        // blocked edge comes after counter 1 has moved on, so a capture would show
        repeat (40) @(posedge clk_sys_i);
        capture_pin_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        bus_rd(ADDR_CAPTURE, d);
        chk(d, exp);
        bus_rd(ADDR_TB1_CSR, d);
        chk(d & 32'h40, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        chk({31'b0, irq_capture_o}, 32'h0);
        $display("test input_capture done");
    endtask

    task automatic t_halt;
        logic [31:0] a, b, c;
        halt_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        bus_rd(ADDR_RELOAD_CNT, a);
        repeat (100) @(posedge clk_sys_i);
        bus_rd(ADDR_RELOAD_CNT, b);
        chk(b, a);
        halt_i <= 1'b0;
        repeat (70) @(posedge clk_sys_i);
        bus_rd(ADDR_RELOAD_CNT, c);
        chk(32'(c !== a), 32'h1);
        $display("test halt_mode done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        miscompares      = 0;
        n_tests          = 0;
        rst_i            = 1'b1;
        avs_address_i    = 8'h00;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_writedata_i  = 32'h0;
        avs_byteenable_i = 4'h0;
        halt_i           = 1'b0;
        capture_pin_i    = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_fixed();
        t_reload();
        t_capture();
        t_halt();
        wrap_up();
    end

    // tests need about 50000 cycles
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        miscompares++;
        $display("mismatch at %0t: watchdog got %h expected %h", $time, 32'h1, 32'h0);
        wrap_up();
    end
endmodule
